// file: shared/pmcg_pkg.sv
// How it works
// - Four programmable clocks, enable/disable/status registers.
// - Programmable clocks come out of reset disabled.
// - Source select picks four clocks, resets slow.
// - Prescaler divides by powers of two, zero passes.
// - Ready flag raises interrupt when enabled, else polled.
// - Source and prescaler accepted in one write.
// - Seventeen peripheral clocks gated with status readback.
// - Enabled peripheral clock is the master clock.
// - One host-bus clock gated, equals master clock.
// - Active prescaler adds 64 new-clock cycles.
// - Master switch latency bounded by slow-clock periods.
// - PLL to PLL switch bounded; same PLL waits lock.
// - Switch to PLL includes its lock count, except from the other PLL.
// - Unlocked PLL clears ready, falls back to slow/main.
// - Master source or prescaler change drops ready.
// - Writing one enables, writing zero changes nothing.
package pmcg_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_SCER = 8'h00;
  localparam logic [7:0] OFS_SCDR = 8'h04;
  localparam logic [7:0] OFS_SCSR = 8'h08;
  localparam logic [7:0] OFS_PCER = 8'h10;
  localparam logic [7:0] OFS_PCDR = 8'h14;
  localparam logic [7:0] OFS_PCSR = 8'h18;
  localparam logic [7:0] OFS_MOR = 8'h20;
  localparam logic [7:0] OFS_MCFR = 8'h24;
  localparam logic [7:0] OFS_PLLA = 8'h28;
  localparam logic [7:0] OFS_PLLB = 8'h2c;
  localparam logic [7:0] OFS_MCKR = 8'h30;
  localparam logic [7:0] OFS_PCK0 = 8'h40;
  localparam logic [7:0] OFS_IER = 8'h60;
  localparam logic [7:0] OFS_IDR = 8'h64;
  localparam logic [7:0] OFS_SR = 8'h68;
  localparam logic [7:0] OFS_IMR = 8'h6c;
  localparam logic [7:0] OFS_EVT = 8'h74;
  localparam logic [7:0] OFS_ICPR = 8'h80;

  // ==========================================================
  // Field positions and reset values
  localparam int NUM_PCK = 4;
  localparam int SC_PCK_LSB = 8;
  localparam int SC_HCK0 = 16;
  localparam logic [31:0] SCSR_FIXED = 32'h0000_0003;
  localparam logic [31:0] PERIPH_MASK = 32'h0007_fffc;
  localparam logic [31:0] PLL_RESET = 32'h0000_3f00;
  localparam int PLL_CNT_LSB = 8;
  localparam int PLL_MUL_LSB = 16;
  localparam int SR_MOSC = 0;
  localparam int SR_LOCKA = 1;
  localparam int SR_LOCKB = 2;
  localparam int SR_MASTER_CLOCK_READY = 3;
  localparam int SR_PCKRDY_LSB = 8;
  localparam int SR_USED = 12;

  // ==========================================================
  // Clock sources, prescaler and master switch timing
  localparam logic [1:0] SRC_SLOW = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_PLLA = 2'h2;
  localparam logic [1:0] SRC_PLLB = 2'h3;
  localparam logic [2:0] PRESCALER_SELECT_MAX = 3'h6;
  localparam logic [7:0] SW_SLOW_TO_X = 8'h05;
  localparam logic [7:0] SW_OTHER_TO_X = 8'h04;
  localparam logic [6:0] PRESCALER_SELECT_EXTRA = 7'h40;

  typedef struct packed {
    logic [2:0] prescaler_select;
    logic [1:0] clock_source_select;
  } pmcg_cfg_t;

  typedef enum logic [2:0] {
    MCK_READY = 3'b001,
    MCK_SLOW_WAIT = 3'b010,
    MCK_PRESCALER_SELECT_WAIT = 3'b100
  } pmcg_mck_state_t;

endpackage : pmcg_pkg

// file: verilog/pmcg_top.sv
`timescale 1ns/1ps
module pmcg_top
  import pmcg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic slow_clock,
  input wire logic main_clock,
  input wire logic pll_a_clock,
  input wire logic pll_b_clock,
  output logic [NUM_PCK-1:0] prog_clock_output,
  output logic [31:0] periph_clk_en,
  output logic host_bus_clock_out,
  output logic [1:0] mck_src_sel,
  output logic [2:0] mck_prescaler_select,
  output logic irq
);

  // ==========================================================
  // Helpers
  function automatic logic [5:0] half_period(input logic [2:0] p);
    logic [2:0] q;
    q = (p > PRESCALER_SELECT_MAX) ? PRESCALER_SELECT_MAX : p;
    half_period = 6'(6'h01 << (q - 3'h1));
  endfunction : half_period

  function automatic logic is_pll(input logic [1:0] s);
    is_pll = s[1];
  endfunction : is_pll

  logic [3:0] src_now;
  logic [3:0] src_prev_q;
  logic [3:0] src_rise;
  logic acc;
  logic wr_acc;
  logic [NUM_PCK-1:0] pck_en_q;
  logic [NUM_PCK-1:0] pck_run_q;
  logic [NUM_PCK-1:0] pck_rdy_q;
  pmcg_cfg_t pck_cfg_q [NUM_PCK];
  pmcg_cfg_t mck_cfg_q;
  logic [31:0] mor_q;
  logic [31:0] pll_cfg_q [2];
  logic [5:0] lock_cnt_q [2];
  logic [1:0] lock_q;
  logic [31:0] imr_q;
  logic [SR_USED-1:0] evt_q;
  logic [SR_USED-1:0] sr_prev_q;
  logic [SR_USED-1:0] sr_now;
  pmcg_mck_state_t mck_state_q;
  logic [7:0] mck_cnt_q;
  logic [7:0] mck_target_q;
  logic mck_unlocked;
  logic mck_rdy;
  logic [31:0] rd_d;

  assign src_now = {pll_b_clock, pll_a_clock, main_clock, slow_clock};
  assign src_rise = src_now & ~src_prev_q;
  assign acc = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_acc = avs_write & ~avs_waitrequest;

  // Source levels are sampled once so edges are seen exactly once.
  // Tracking through reset too avoids a false edge on release when a
  // source happens to be high.
  always_ff @(posedge sys_clk)
  begin
    src_prev_q <= src_now;
  end

  // ==========================================================
  // Avalon slave: one wait cycle, then the access completes.
  // Waitrequest idles high so no access can slip in unseen.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      avs_waitrequest <= 1'b1;
    else if (acc)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~(avs_read | avs_write);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & avs_waitrequest)
      avs_readdata <= rd_d;
  end

  // Read mux; write-only and unmapped offsets read as zero.
  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (avs_address)
      OFS_SCSR: rd_d = SCSR_FIXED
                       | (32'(host_bus_clock_out) << SC_HCK0)
                       | (32'(pck_en_q) << SC_PCK_LSB);
      OFS_PCSR: rd_d = periph_clk_en;
      OFS_MOR: rd_d = mor_q;
      OFS_MCFR: rd_d = 32'h0000_0000;
      OFS_PLLA: rd_d = pll_cfg_q[0];
      OFS_PLLB: rd_d = pll_cfg_q[1];
      OFS_MCKR: rd_d = 32'(mck_cfg_q);
      OFS_SR: rd_d = 32'(sr_now);
      OFS_IMR: rd_d = imr_q;
      OFS_EVT: rd_d = 32'(evt_q);
      default:
      begin
        if (avs_address[7:4] == OFS_PCK0[7:4] && avs_address[1:0] == 2'h0)
          rd_d = 32'(pck_cfg_q[avs_address[3:2]]);
      end
    endcase
  end

  // ==========================================================
  // System and peripheral clock gates (set/clear style).
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pck_en_q <= '0;
      host_bus_clock_out <= 1'b0;
    end
    else if (wr_acc && avs_address == OFS_SCER)
    begin
      pck_en_q <= pck_en_q | avs_writedata[SC_PCK_LSB +: NUM_PCK];
      host_bus_clock_out <= host_bus_clock_out | avs_writedata[SC_HCK0];
    end
    else if (wr_acc && avs_address == OFS_SCDR)
    begin
      pck_en_q <= pck_en_q & ~avs_writedata[SC_PCK_LSB +: NUM_PCK];
      host_bus_clock_out <= host_bus_clock_out & ~avs_writedata[SC_HCK0];
    end
  end

  // Gate enables feed a latch-based gate on the master clock, so
  // the gated clock is the master clock itself, never divided.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      periph_clk_en <= 32'h0000_0000;
    else if (wr_acc && avs_address == OFS_PCER)
      periph_clk_en <= periph_clk_en | (avs_writedata & PERIPH_MASK);
    else if (wr_acc && avs_address == OFS_PCDR)
      periph_clk_en <= periph_clk_en & ~avs_writedata;
  end

  // ==========================================================
  // Configuration registers.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      mor_q <= 32'h0000_0000;
      mck_cfg_q <= '0;
      for (int i = 0; i < NUM_PCK; i++)
        pck_cfg_q[i] <= '{prescaler_select: 3'h0, clock_source_select: SRC_SLOW};
      for (int j = 0; j < 2; j++)
        pll_cfg_q[j] <= PLL_RESET;
    end
    else if (wr_acc)
    begin
      if (avs_address == OFS_MOR)
        mor_q <= avs_writedata;
      if (avs_address == OFS_MCKR)
        mck_cfg_q <= avs_writedata[4:0];
      if (avs_address == OFS_PLLA)
        pll_cfg_q[0] <= avs_writedata;
      if (avs_address == OFS_PLLB)
        pll_cfg_q[1] <= avs_writedata;
      // Both fields land in one write; no partial sequence needed.
      if (avs_address[7:4] == OFS_PCK0[7:4] && avs_address[1:0] == 2'h0)
        pck_cfg_q[avs_address[3:2]] <= avs_writedata[4:0];
    end
  end

  // ==========================================================
  // PLL lock timers count slow-clock edges after each write.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      lock_q <= 2'h0;
      lock_cnt_q[0] <= 6'h00;
      lock_cnt_q[1] <= 6'h00;
    end
    else
    begin
      for (int j = 0; j < 2; j++)
      begin
        if (wr_acc && avs_address == (j == 0 ? OFS_PLLA : OFS_PLLB))
        begin
          lock_q[j] <= 1'b0;
          lock_cnt_q[j] <= 6'h00;
        end
        else if (!lock_q[j] && src_rise[0]
                 && pll_cfg_q[j][PLL_MUL_LSB +: 11] != 11'h000)
        begin
          if (lock_cnt_q[j] == pll_cfg_q[j][PLL_CNT_LSB +: 6])
            lock_q[j] <= 1'b1;
          else
            lock_cnt_q[j] <= lock_cnt_q[j] + 6'h01;
        end
      end
    end
  end

  // ==========================================================
  // Master clock switch timer. The switch wait counts slow-clock periods and
  // the prescaler wait new-clock edges: sub-period fractions of fast clocks are covered.
  assign mck_unlocked = is_pll(mck_cfg_q.clock_source_select) && !lock_q[mck_cfg_q.clock_source_select[0]];
  assign mck_rdy = (mck_state_q == MCK_READY) && !mck_unlocked;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      mck_state_q <= MCK_READY;
      mck_cnt_q <= 8'h00;
      mck_target_q <= 8'h00;
    end
    else if (wr_acc && avs_address == OFS_MCKR
             && avs_writedata[4:0] != 5'(mck_cfg_q))
    begin
      mck_state_q <= MCK_SLOW_WAIT;
      mck_cnt_q <= 8'h00;
      // Slow-clock part of the worst case, plus the lock wait of the
      // target PLL, except on a jump from one PLL to the other.
      mck_target_q <= ((mck_cfg_q.clock_source_select == SRC_SLOW) ? SW_SLOW_TO_X
                       : SW_OTHER_TO_X)
                      + ((is_pll(avs_writedata[1:0])
                          && (!is_pll(mck_cfg_q.clock_source_select)
                              || avs_writedata[1:0] == mck_cfg_q.clock_source_select))
                         ? 8'(pll_cfg_q[avs_writedata[0]][PLL_CNT_LSB +: 6])
                         : 8'h00);
    end
    else
    begin
      case (mck_state_q)
        MCK_READY: mck_cnt_q <= 8'h00;
        MCK_SLOW_WAIT:
        begin
          if (src_rise[0])
          begin
            if (mck_cnt_q + 8'h01 >= mck_target_q)
            begin
              mck_cnt_q <= 8'h00;
              mck_state_q <= (mck_cfg_q.prescaler_select != 3'h0) ? MCK_PRESCALER_SELECT_WAIT
                             : MCK_READY;
            end
            else
              mck_cnt_q <= mck_cnt_q + 8'h01;
          end
        end
        MCK_PRESCALER_SELECT_WAIT:
        begin
          if (src_rise[mck_cfg_q.clock_source_select])
          begin
            if (mck_cnt_q + 8'h01 >= 8'(PRESCALER_SELECT_EXTRA))
              mck_state_q <= MCK_READY;
            else
              mck_cnt_q <= mck_cnt_q + 8'h01;
          end
        end
        default: mck_state_q <= MCK_READY;
      endcase
    end
  end

  // Selection given to the glitch-free master mux: the new choice
  // is released once the slow-clock wait is over, before any prescaler wait.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      mck_src_sel <= SRC_SLOW;
      mck_prescaler_select <= 3'h0;
    end
    else if (mck_unlocked)
      mck_src_sel <= mck_cfg_q.clock_source_select[0] ? SRC_MAIN : SRC_SLOW;
    else if (mck_state_q != MCK_SLOW_WAIT)
    begin
      mck_src_sel <= mck_cfg_q.clock_source_select;
      mck_prescaler_select <= mck_cfg_q.prescaler_select;
    end
  end

  // ==========================================================
  // Programmable clock generators.
  for (genvar g = 0; g < NUM_PCK; g++)
  begin : g_pck
    logic [5:0] cnt_q;
    logic sel;
    assign sel = src_now[pck_cfg_q[g].clock_source_select];

    // Starts low and stops only while low: no short pulses.
    always_ff @(posedge sys_clk)
    begin
      if (!reset_n)
      begin
        pck_run_q[g] <= 1'b0;
        prog_clock_output[g] <= 1'b0;
        pck_rdy_q[g] <= 1'b0;
        cnt_q <= 6'h00;
      end
      else if (!pck_en_q[g] && !prog_clock_output[g])
      begin
        pck_run_q[g] <= 1'b0;
        pck_rdy_q[g] <= 1'b0;
        cnt_q <= 6'h00;
      end
      else
      begin
        pck_run_q[g] <= 1'b1;
        if (prog_clock_output[g])
          pck_rdy_q[g] <= 1'b1;
        if (pck_cfg_q[g].prescaler_select == 3'h0)
          prog_clock_output[g] <= sel;
        else if (src_rise[pck_cfg_q[g].clock_source_select])
        begin
          if (cnt_q + 6'h01 >= half_period(pck_cfg_q[g].prescaler_select))
          begin
            cnt_q <= 6'h00;
            prog_clock_output[g] <= ~prog_clock_output[g];
          end
          else
            cnt_q <= cnt_q + 6'h01;
        end
      end
    end

    a_pck_off_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !pck_en_q[g] && !pck_run_q[g] |=> !prog_clock_output[g])
      else $error("Disabled clock output toggled.");
    a_prescaler_select_pass: assert property (@(posedge sys_clk) disable iff (!reset_n)
      pck_en_q[g] && pck_run_q[g] && pck_cfg_q[g].prescaler_select == 3'h0
      && $stable(pck_cfg_q[g]) |=> prog_clock_output[g] == $past(sel))
      else $error("Undivided clock does not follow source.");
  end

  // ==========================================================
  // Status, events and interrupt. A rising status flag sets a
  // sticky event; the set wins over a clearing write.
  assign sr_now = {pck_rdy_q, 4'h0, mck_rdy, lock_q[1], lock_q[0], mor_q[0]};

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sr_prev_q <= '0;
      evt_q <= '0;
    end
    else
    begin
      sr_prev_q <= sr_now;
      evt_q <= (evt_q & ~((wr_acc && avs_address == OFS_EVT)
                          ? avs_writedata[SR_USED-1:0] : '0))
               | (sr_now & ~sr_prev_q);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      imr_q <= 32'h0000_0000;
    else if (wr_acc && avs_address == OFS_IER)
      imr_q <= imr_q | avs_writedata;
    else if (wr_acc && avs_address == OFS_IDR)
      imr_q <= imr_q & ~avs_writedata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(32'(evt_q) & imr_q);
  end

  // ==========================================================
  // Checks.
  a_scer_enable: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_acc && avs_address == OFS_SCER && avs_writedata[SC_PCK_LSB]
    |=> pck_en_q[0])
    else $error("Enable write did not enable clock 0.");
  a_scdr_disable: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_acc && avs_address == OFS_SCDR && avs_writedata[SC_PCK_LSB + 1]
    |=> !pck_en_q[1])
    else $error("Disable write did not disable clock 1.");
  a_periph_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_acc && avs_address == OFS_PCER && avs_writedata[4]
    |=> periph_clk_en[4] && !periph_clk_en[0])
    else $error("Peripheral enable write mishandled.");
  a_hck_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_acc && avs_address == OFS_SCDR && avs_writedata[SC_HCK0]
    |=> !host_bus_clock_out)
    else $error("Host bus clock not disabled.");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
    |(32'(evt_q) & imr_q) |=> irq)
    else $error("Unmasked event without interrupt.");
  a_mck_drop: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_acc && avs_address == OFS_MCKR && avs_writedata[4:0] != 5'(mck_cfg_q)
    |=> !mck_rdy ##1 !mck_rdy)
    else $error("Master ready did not drop on change.");
  a_mck_fallback: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mck_cfg_q.clock_source_select == SRC_PLLA && !lock_q[0] |=> mck_src_sel == SRC_SLOW
    || $past(mck_cfg_q.clock_source_select) != SRC_PLLA)
    else $error("No slow-clock fallback while PLL A unlocked.");
  a_bus_answer: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (avs_read || avs_write) && avs_waitrequest && !$past(acc)
    |=> !avs_waitrequest)
    else $error("Bus access not answered after one wait.");

endmodule : pmcg_top

// file: dv/pmcg_top_tb.sv
`timescale 1ns/1ps
module pmcg_top_tb
  import pmcg_pkg::*;
;
  logic sys_clk;
  logic reset_n;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic slow_clock;
  logic main_clock;
  logic pll_a_clock;
  logic pll_b_clock;
  logic [NUM_PCK-1:0] prog_clock_output;
  logic [31:0] periph_clk_en;
  logic host_bus_clock_out;
  logic [1:0] mck_src_sel;
  logic [2:0] mck_prescaler_select;
  logic irq;
  int fails;
  int total_checks;
  int i;
  int cyc;
  int per;
  logic [31:0] q;
  logic [31:0] w;
  logic [31:0] exp_q;
  logic [31:0] rnd;
  logic [7:0] div_q;
  logic [2:0] six_q;
  logic [7:0] rs_a [13] = '{8'h08, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2c,
    8'h30, 8'h40, 8'h44, 8'h68, 8'h6c, 8'h0c, 8'h00};
  logic [31:0] rs_v [13] = '{32'h3, 32'h0, 32'h0, 32'h0, 32'h3f00,
    32'h3f00, 32'h0, 32'h0, 32'h0, 32'h8, 32'h0, 32'h0, 32'h0};
  int pc_css [7] = '{0, 1, 2, 3, 1, 0, 2};
  int pc_prescaler_select [7] = '{0, 1, 2, 3, 5, 6, 7};
  int src_per [4] = '{16, 4, 6, 8};
  localparam logic [31:0] SC_MASK = 32'h0001_0f00;

  pmcg_top pmcg_top_i (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .slow_clock(slow_clock),
    .main_clock(main_clock),
    .pll_a_clock(pll_a_clock),
    .pll_b_clock(pll_b_clock),
    .prog_clock_output(prog_clock_output),
    .periph_clk_en(periph_clk_en),
    .host_bus_clock_out(host_bus_clock_out),
    .mck_src_sel(mck_src_sel),
    .mck_prescaler_select(mck_prescaler_select),
    .irq(irq)
  );

  // ==========================================================
  // Clocks and source waveforms
  // Sources are derived from the bus clock so that every level is seen by
  // the sampling logic; periods are 16, 4, 6 and 8 bus cycles.
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    div_q <= div_q + 8'h01;
    six_q <= (six_q == 3'h5) ? 3'h0 : six_q + 3'h1;
    slow_clock <= div_q[3];
    main_clock <= div_q[1];
    pll_b_clock <= div_q[2];
    pll_a_clock <= six_q < 3'h3;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] inr(input int c, input int lo,
                                      input int hi);
    return {31'h0, c >= lo && c <= hi};
  endfunction : inr

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task print_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // One bus access; the request is held until waitrequest is seen low.
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50)
    begin
      fails++;
      $display("MISMATCH at %0t: bus access never answered", $time);
    end
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd

  // Polls a status bit; a timeout after 400 reads counts as a mismatch.
  task poll(input logic [7:0] a, input int b, input logic v,
            output int c);
    logic [31:0] r;
    time t0;
    int k;
    t0 = $time;
    k = 0;
    do
    begin
      rd(a, r);
      k++;
    end
    while (r[b] !== v && k < 400);
    c = int'(($time - t0) / 20);
    if (r[b] !== v)
    begin
      fails++;
      $display("MISMATCH at %0t: status bit never reached", $time);
    end
  endtask : poll

  // Measures the period of programmable output 0 in bus cycles.
  task measure(output int p);
    logic prev;
    int n;
    int t0;
    prev = prog_clock_output[0];
    n = 0;
    t0 = -1;
    p = 0;
    while (n < 3000 && p == 0)
    begin
      @(posedge sys_clk);
      n++;
      if (prog_clock_output[0] === 1'b1 && prev !== 1'b1)
      begin
        if (t0 >= 0)
          p = n - t0;
        else
          t0 = n;
      end
      prev = prog_clock_output[0];
    end
  endtask : measure

  // Checks the fallback source while a reprogrammed PLL relocks.
  task pll_unlock(input logic [7:0] pa, input logic [31:0] pv,
                  input logic [1:0] sel, input logic [1:0] fb);
    wr(pa, pv);
    rd(OFS_SR, q);
    check({31'h0, q[SR_MASTER_CLOCK_READY]}, 32'h0);
    check({30'h0, mck_src_sel}, {30'h0, fb});
    poll(OFS_SR, SR_MASTER_CLOCK_READY, 1'b1, cyc);
    check({30'h0, mck_src_sel}, {30'h0, sel});
  endtask : pll_unlock

  // ==========================================================
  // Watchdog against a hung handshake or a missing flag.
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    fails = 0;
    total_checks = 0;
    rnd = 32'h7d37;
    div_q = 8'h00;
    six_q = 3'h0;
    {slow_clock, main_clock, pll_a_clock, pll_b_clock} = 4'h0;
    reset_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 13; i++)
    begin
      rd(rs_a[i], q);
      check(q, rs_v[i]);
    end
    // Peripheral gates with random enable and disable masks.
    exp_q = 32'h0;
    for (i = 0; i < 10; i++)
    begin
      w = (i == 0) ? 32'hffff_ffff : rnd;
      rnd = lfsr(rnd);
      wr(OFS_PCER, w);
      exp_q = exp_q | (w & PERIPH_MASK);
      w = (i == 1) ? 32'hffff_ffff : rnd;
      rnd = lfsr(rnd);
      wr(OFS_PCDR, w);
      exp_q = exp_q & ~(w & PERIPH_MASK);
      rd(OFS_PCSR, q);
      check(q, exp_q);
      check(periph_clk_en, exp_q);
    end
    // System clock gates: a zero bit in either write changes nothing.
    exp_q = SCSR_FIXED;
    for (i = 0; i < 8; i++)
    begin
      w = rnd;
      rnd = lfsr(rnd);
      wr(OFS_SCER, w);
      exp_q = exp_q | (w & SC_MASK);
      w = rnd;
      rnd = lfsr(rnd);
      wr(OFS_SCDR, w);
      exp_q = exp_q & ~(w & SC_MASK);
      rd(OFS_SCSR, q);
      check(q, exp_q);
      check({31'h0, host_bus_clock_out}, {31'h0, exp_q[SC_HCK0]});
    end
    wr(OFS_SCDR, 32'hffff_ffff);
    rd(OFS_SCSR, q);
    check(q, SCSR_FIXED);
    check({31'h0, irq}, 32'h0);
    // Programmable clock 0 over every source and prescaler values 0-3 and 5-7.
    wr(OFS_EVT, 32'hffff_ffff);
    wr(OFS_IER, 32'h100);
    rd(OFS_IMR, q);
    check(q, 32'h100);
    for (i = 0; i < 7; i++)
    begin
      wr(OFS_SCDR, 32'h100);
      poll(OFS_SR, 8, 1'b0, cyc);
      check({31'h0, prog_clock_output[0]}, 32'h0);
      wr(OFS_EVT, 32'h100);
      repeat (2) @(posedge sys_clk);
      check({31'h0, irq}, 32'h0);
      w = (pc_prescaler_select[i] << 2) | pc_css[i];
      wr(OFS_PCK0, w);
      rd(OFS_PCK0, q);
      check(q, w);
      wr(OFS_SCER, 32'h100);
      poll(OFS_SR, 8, 1'b1, cyc);
      repeat (2) @(posedge sys_clk);
      check({31'h0, irq}, 32'h1);
      measure(per);
      check(per, src_per[pc_css[i]] << ((pc_prescaler_select[i] == 7) ? 6 :
        pc_prescaler_select[i]));
    end
    // Masked event stays visible for polling.
    wr(OFS_IDR, 32'h100);
    rd(OFS_IMR, q);
    check(q, 32'h0);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    rd(OFS_EVT, q);
    check(q & 32'h100, 32'h100);
    // Master clock switching with latency windows.
    wr(OFS_MCKR, 32'h1);
    rd(OFS_SR, q);
    check({31'h0, q[SR_MASTER_CLOCK_READY]}, 32'h0);
    poll(OFS_SR, SR_MASTER_CLOCK_READY, 1'b1, cyc);
    check(inr(cyc, 0, 108), 32'h1);
    check({27'h0, mck_prescaler_select, mck_src_sel}, {27'h0, 3'h0, SRC_MAIN});
    wr(OFS_MCKR, 32'h5);
    poll(OFS_SR, SR_MASTER_CLOCK_READY, 1'b1, cyc);
    check(inr(cyc, 252, 360), 32'h1);
    check({27'h0, mck_prescaler_select, mck_src_sel}, {27'h0, 3'h1, SRC_MAIN});
    wr(OFS_MCKR, 32'h1);
    poll(OFS_SR, SR_MASTER_CLOCK_READY, 1'b1, cyc);
    wr(OFS_PLLA, 32'h2003_0605);
    poll(OFS_SR, SR_LOCKA, 1'b1, cyc);
    wr(OFS_MCKR, 32'h2);
    poll(OFS_SR, SR_MASTER_CLOCK_READY, 1'b1, cyc);
    check(inr(cyc, 140, 200), 32'h1);
    check({30'h0, mck_src_sel}, {30'h0, SRC_PLLA});
    wr(OFS_PLLB, 32'h0004_0805);
    poll(OFS_SR, SR_LOCKB, 1'b1, cyc);
    wr(OFS_MCKR, 32'h3);
    poll(OFS_SR, SR_MASTER_CLOCK_READY, 1'b1, cyc);
    check(inr(cyc, 0, 150), 32'h1);
    check({30'h0, mck_src_sel}, {30'h0, SRC_PLLB});
    pll_unlock(OFS_PLLB, 32'h0004_0405, SRC_PLLB, SRC_MAIN);
    wr(OFS_MCKR, 32'h2);
    poll(OFS_SR, SR_MASTER_CLOCK_READY, 1'b1, cyc);
    pll_unlock(OFS_PLLA, 32'h2003_0405, SRC_PLLA, SRC_SLOW);
    print_verdict();
  end
endmodule : pmcg_top_tb
